//--- rtl/apdu_pkg.sv
package apdu_pkg;
  localparam int HDR_LEN = 5;
  localparam int RSP_DEPTH = 256;
  localparam int CMD_DEPTH = 256;
  localparam int BUF_W = 8;
  localparam logic [7:0] INS_GET_RESP = 8'hC0;
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam logic [7:0] PB_NULL = 8'h60;
  localparam logic [7:0] PB_MORE = 8'h61;
  localparam logic [7:0] PB_WRONG_LE = 8'h6C;
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW2_OK = 8'h00;
  localparam logic [7:0] SW1_BADP = 8'h6B;
  localparam logic [7:0] SW2_BADP = 8'h00;
  localparam logic [7:0] SW1_PIN = 8'h63;
  localparam logic [7:0] SW1_WARN = 8'h62;
  localparam logic [7:0] SW1_NOINFO = 8'h6F;
  localparam logic [7:0] SW2_NOINFO = 8'h00;
  localparam logic [7:0] GR_P12 = 8'h00;
  localparam logic [7:0] LE_MAX = 8'h00;
  localparam logic [3:0] PIN_HI = 4'hC;
  localparam logic [3:0] APP_HI = 4'h9;

  typedef enum logic [3:0] {
    C_HDR = 4'b0000, C_DEC = 4'b0001, C_ASK = 4'b0010, C_CHK = 4'b0011,
    C_ACK = 4'b0100, C_RXD = 4'b0101, C_WAIT = 4'b0110, C_SEND = 4'b0111,
    C_SW1 = 4'b1000, C_SW2 = 4'b1001
  } card_st_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_HDR = 3'b001, T_PROC = 3'b010, T_SW2 = 3'b011,
    T_DOUT = 3'b100, T_DIN = 3'b101
  } term_st_t;

  // A success pair is never allowed on an abnormal ending
  function automatic logic [15:0] fix_sw(input logic [7:0] s1, input logic [7:0] s2);
    if (s1 == SW1_OK && s2 == SW2_OK) begin
      fix_sw = {SW1_NOINFO, SW2_NOINFO};
    end else begin
      fix_sw = {s1, s2};
    end
  endfunction
endpackage

//--- rtl/apdu_link_if.sv
`timescale 1ns/100ps
interface apdu_link_if;
  logic t2c_valid;
  logic t2c_ready;
  logic [7:0] t2c_data;
  logic c2t_valid;
  logic c2t_ready;
  logic [7:0] c2t_data;
  modport card (
    input t2c_valid,
    input t2c_data,
    output t2c_ready,
    output c2t_valid,
    output c2t_data,
    input c2t_ready
  );
  modport term (
    output t2c_valid,
    output t2c_data,
    input t2c_ready,
    input c2t_valid,
    input c2t_data,
    output c2t_ready
  );
endinterface

//--- rtl/card_apdu_end.sv
`timescale 1ns/100ps
// Functional notes
// RULE1: Case 2 bad Le: send 6C and Luicc
// RULE2: Terminal resends header with corrected P3
// RULE3: Case 2 abnormal: error status, never 9000
// RULE4: Le equals Luicc: ack, data, then status
// RULE5: Le below Luicc: data then 61 remainder
// RULE6: Outgoing data header acknowledged with INS byte
// RULE7: Case 4 normal: 61 with response length
// RULE8: Case 4 end: 61xx or error, not 9000
// RULE9: GET RESPONSE: C0 ack, data, 9000
// RULE10: Short GET RESPONSE: leading bytes, 61 rest
// RULE11: Follow-up GET RESPONSE continues, ends 9000
// RULE12: Bad P1/P2 rejected with 6B00, no data
// RULE13: Empty PIN verify gives 63 CX
// RULE14: Block protocol carries units without procedure bytes
// RULE15: Terminal selects block protocol before using it
// RULE16: Case 4 warning: terminal fetches with Le 00
// RULE17: Status after header: terminal sends no data
// RULE18: Pending count decremented, cleared by new command
// RULE19: Bytewise input, five-byte header, bytewise replies
module card_apdu_end (
  input wire logic clk,
  input wire logic arst_n,
  apdu_link_if.card lnk,
  input wire logic t1_mode,
  input wire logic [3:0] pin_retries,
  output logic hdr_valid,
  output logic [7:0] hdr_ins,
  output logic [7:0] hdr_p1,
  output logic [7:0] hdr_p2,
  output logic [7:0] hdr_p3,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic cmd_end,
  input wire logic ans_valid,
  input wire logic ans_badp,
  input wire logic ans_ok,
  input wire logic ans_indata,
  input wire logic [7:0] ans_len,
  input wire logic [7:0] ans_sw1,
  input wire logic [7:0] ans_sw2,
  input wire logic rsp_we,
  input wire logic [7:0] rsp_addr,
  input wire logic [7:0] rsp_wdata
);
  import apdu_pkg::*;

  card_st_t st_ff, nxt_st;
  logic [7:0] hdr_ff [HDR_LEN];
  logic [7:0] rsp_mem [RSP_DEPTH];
  logic [2:0] idx_ff;
  logic [7:0] cnt_ff, pend_ff, rdp_ff, sw1_ff, sw2_ff, keep1_ff, keep2_ff;
  logic dir_in_ff, t2c_ready_ff, hdr_valid_ff, cmd_valid_ff, cmd_end_ff;
  logic [7:0] cmd_data_ff;
  logic head_vld_ff, tail_vld_ff;
  logic [BUF_W-1:0] head_ff, tail_ff;
  logic rx_ok, push_req, push_ok, pop, pin_empty;
  logic [7:0] push_data, ins, p3;
  logic [15:0] bad_sw;

  assign ins = hdr_ff[1];
  assign p3 = hdr_ff[4];
  assign rx_ok = lnk.t2c_valid & t2c_ready_ff;
  assign pop = head_vld_ff & lnk.c2t_ready;
  assign push_ok = push_req & ~tail_vld_ff;
  assign pin_empty = (ins == INS_VERIFY) && (p3 == 8'h00);
  assign bad_sw = fix_sw(ans_sw1, ans_sw2);

  assign lnk.t2c_ready = t2c_ready_ff;
  assign lnk.c2t_valid = head_vld_ff;
  assign lnk.c2t_data = head_ff;
  assign hdr_valid = hdr_valid_ff;
  assign hdr_ins = hdr_ff[1];
  assign hdr_p1 = hdr_ff[2];
  assign hdr_p2 = hdr_ff[3];
  assign hdr_p3 = hdr_ff[4];
  assign cmd_valid = cmd_valid_ff;
  assign cmd_data = cmd_data_ff;
  assign cmd_end = cmd_end_ff;

  // Bytes leave one at a time through the two-entry buffer
  always_comb begin
    push_req = 1'b0;
    push_data = 8'h00;
    case (st_ff)
      C_ACK: begin
        push_req = ~t1_mode; // RULE14
        push_data = ins; // RULE6 RULE9
      end
      C_SEND: begin
        push_req = 1'b1;
        push_data = rsp_mem[rdp_ff];
      end
      C_SW1: begin
        push_req = 1'b1;
        push_data = sw1_ff;
      end
      C_SW2: begin
        push_req = 1'b1;
        push_data = sw2_ff;
      end
      default: begin
        push_req = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      C_HDR: if (rx_ok && idx_ff == 3'(HDR_LEN - 1)) nxt_st = C_DEC; // RULE19
      C_DEC: begin
        if (ins != INS_GET_RESP) nxt_st = C_ASK;
        else if (pend_ff == 8'h00) nxt_st = C_SW1;
        else nxt_st = C_CHK;
      end
      C_ASK: begin
        if (ans_valid) begin
          if (ans_badp || pin_empty || !ans_ok) nxt_st = C_SW1;
          else if (ans_indata) nxt_st = C_ACK;
          else if (ans_len == 8'h00) nxt_st = C_SW1;
          else nxt_st = C_CHK;
        end
      end
      C_CHK: nxt_st = (p3 == LE_MAX || p3 > pend_ff) ? C_SW1 : C_ACK; // RULE1
      C_ACK: if (t1_mode || push_ok) nxt_st = dir_in_ff ? C_RXD : C_SEND;
      C_RXD: if (rx_ok && cnt_ff == 8'h01) nxt_st = C_WAIT;
      C_WAIT: if (ans_valid) nxt_st = C_SW1;
      C_SEND: if (push_ok && cnt_ff == 8'h01) nxt_st = C_SW1;
      C_SW1: if (push_ok) nxt_st = C_SW2;
      C_SW2: if (push_ok) nxt_st = C_HDR;
      default: nxt_st = C_HDR;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= C_HDR;
      t2c_ready_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      t2c_ready_ff <= (nxt_st == C_HDR) || (nxt_st == C_RXD);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < HDR_LEN; i++) begin
        hdr_ff[i] <= 8'h00;
      end
      idx_ff <= 3'h0;
    end else if (st_ff == C_HDR && rx_ok) begin
      hdr_ff[idx_ff] <= lnk.t2c_data;
      idx_ff <= (idx_ff == 3'(HDR_LEN - 1)) ? 3'h0 : idx_ff + 3'h1;
    end
  end

  // Decision and status datapath
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 8'h00;
      pend_ff <= 8'h00;
      rdp_ff <= 8'h00;
      sw1_ff <= 8'h00;
      sw2_ff <= 8'h00;
      keep1_ff <= 8'h00;
      keep2_ff <= 8'h00;
      dir_in_ff <= 1'b0;
    end else begin
      case (st_ff)
        C_DEC: begin
          dir_in_ff <= 1'b0;
          if (ins == INS_GET_RESP) begin
            {keep1_ff, keep2_ff} <= {SW1_OK, SW2_OK}; // RULE9 RULE11
            {sw1_ff, sw2_ff} <= {SW1_NOINFO, SW2_NOINFO};
          end else begin
            pend_ff <= 8'h00; // RULE18
            rdp_ff <= 8'h00;
          end
        end
        C_ASK: if (ans_valid) begin
          if (ans_badp) begin
            {sw1_ff, sw2_ff} <= {SW1_BADP, SW2_BADP}; // RULE12
          end else if (pin_empty) begin
            {sw1_ff, sw2_ff} <= {SW1_PIN, PIN_HI, pin_retries}; // RULE13
          end else if (!ans_ok) begin
            {sw1_ff, sw2_ff} <= bad_sw; // RULE3
          end else if (ans_indata) begin
            dir_in_ff <= 1'b1;
            cnt_ff <= p3;
          end else if (ans_len == 8'h00) begin
            {sw1_ff, sw2_ff} <= {ans_sw1, ans_sw2};
          end else begin
            pend_ff <= ans_len;
            rdp_ff <= 8'h00;
            {keep1_ff, keep2_ff} <= {ans_sw1, ans_sw2};
          end
        end
        C_CHK: begin
          if (p3 == LE_MAX || p3 > pend_ff) begin
            {sw1_ff, sw2_ff} <= {PB_WRONG_LE, pend_ff}; // RULE1
          end else begin
            cnt_ff <= p3;
          end
        end
        C_RXD: if (rx_ok) cnt_ff <= cnt_ff - 8'h01;
        C_WAIT: if (ans_valid) begin
          if (ans_badp) begin
            {sw1_ff, sw2_ff} <= {SW1_BADP, SW2_BADP}; // RULE12
          end else if (!ans_ok) begin
            {sw1_ff, sw2_ff} <= bad_sw; // RULE8
          end else if (ans_len != 8'h00) begin
            pend_ff <= ans_len;
            rdp_ff <= 8'h00;
            {sw1_ff, sw2_ff} <= {PB_MORE, ans_len}; // RULE7 RULE8
          end else begin
            // A bare success here would leave the terminal nothing to fetch
            {sw1_ff, sw2_ff} <= bad_sw; // RULE8
          end
        end
        C_SEND: if (push_ok) begin
          rdp_ff <= rdp_ff + 8'h01;
          pend_ff <= pend_ff - 8'h01; // RULE18
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h01) begin
            if (pend_ff == 8'h01) begin
              {sw1_ff, sw2_ff} <= {keep1_ff, keep2_ff}; // RULE4 RULE11
            end else begin
              {sw1_ff, sw2_ff} <= {PB_MORE, pend_ff - 8'h01}; // RULE5 RULE10
            end
          end
        end
        default: begin
          dir_in_ff <= dir_in_ff;
        end
      endcase
    end
  end

  // Application-side strobes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hdr_valid_ff <= 1'b0;
      cmd_valid_ff <= 1'b0;
      cmd_end_ff <= 1'b0;
      cmd_data_ff <= 8'h00;
    end else begin
      hdr_valid_ff <= (st_ff == C_DEC) && (ins != INS_GET_RESP);
      cmd_valid_ff <= (st_ff == C_RXD) && rx_ok;
      cmd_end_ff <= (st_ff == C_RXD) && rx_ok && (cnt_ff == 8'h01);
      if (st_ff == C_RXD && rx_ok) cmd_data_ff <= lnk.t2c_data;
    end
  end

  // Response store has no reset; the application fills it before answering
  always_ff @(posedge clk) begin
    if (rsp_we) rsp_mem[rsp_addr] <= rsp_wdata;
  end

  // Two-entry buffer: a stalled terminal holds replies instead of losing them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      head_vld_ff <= 1'b0;
      tail_vld_ff <= 1'b0;
      head_ff <= 8'h00;
      tail_ff <= 8'h00;
    end else if (pop) begin
      if (tail_vld_ff) begin
        head_ff <= tail_ff;
        tail_vld_ff <= 1'b0;
      end else begin
        head_vld_ff <= push_ok;
        head_ff <= push_data;
      end
    end else if (push_ok) begin
      if (head_vld_ff) begin
        tail_ff <= push_data;
        tail_vld_ff <= 1'b1;
      end else begin
        head_ff <= push_data;
        head_vld_ff <= 1'b1;
      end
    end
  end
endmodule

//--- rtl/term_apdu_end.sv
`timescale 1ns/100ps
module term_apdu_end (
  input wire logic clk,
  input wire logic arst_n,
  apdu_link_if.term lnk,
  input wire logic t1_mode,
  input wire logic t1_active,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_cla,
  input wire logic [7:0] req_ins,
  input wire logic [7:0] req_p1,
  input wire logic [7:0] req_p2,
  input wire logic [7:0] req_p3,
  input wire logic req_has_data,
  input wire logic dat_we,
  input wire logic [7:0] dat_addr,
  input wire logic [7:0] dat_wdata,
  input wire logic rsp_stall,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic done,
  output logic [7:0] done_sw1,
  output logic [7:0] done_sw2
);
  import apdu_pkg::*;

  term_st_t st_ff, nxt_st;
  logic [7:0] hdr_ff [HDR_LEN];
  logic [7:0] dat_mem [CMD_DEPTH];
  logic [7:0] idx_ff, cnt_ff, hold_ff, tx_data_ff, rsp_data_ff, sw1_ff, sw2_ff;
  logic tx_vld_ff, rx_rdy_ff, has_data_ff, sent_ff, case4_ff;
  logic req_ready_ff, rsp_valid_ff, done_ff;
  logic rx_ok, tx_free, warn;
  logic [7:0] b;

  assign b = lnk.c2t_data;
  assign rx_ok = lnk.c2t_valid & rx_rdy_ff;
  assign tx_free = ~tx_vld_ff | lnk.t2c_ready;
  // Warnings and application statuses other than success trigger a fetch
  assign warn = (hold_ff == SW1_WARN) || (hold_ff == SW1_PIN) ||
                (hold_ff[7:4] == APP_HI && !(hold_ff == SW1_OK && b == SW2_OK));
  assign lnk.t2c_valid = tx_vld_ff;
  assign lnk.t2c_data = tx_data_ff;
  assign lnk.c2t_ready = rx_rdy_ff;
  assign req_ready = req_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign done = done_ff;
  assign done_sw1 = sw1_ff;
  assign done_sw2 = sw2_ff;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      T_IDLE: if (req_valid && req_ready_ff) nxt_st = T_HDR;
      T_HDR: begin
        if (tx_free && idx_ff == 8'(HDR_LEN - 1)) begin
          if (t1_mode && has_data_ff) nxt_st = T_DOUT; // RULE14
          else if (t1_mode && hdr_ff[4] != 8'h00) nxt_st = T_DIN;
          else nxt_st = T_PROC;
        end
      end
      T_PROC: begin
        if (rx_ok && b != PB_NULL) begin
          if (b == hdr_ff[1] || b == ~hdr_ff[1]) begin
            nxt_st = (has_data_ff && !sent_ff) ? T_DOUT : T_DIN;
          end else begin
            nxt_st = T_SW2; // RULE17
          end
        end
      end
      T_SW2: begin
        if (rx_ok) begin
          if (hold_ff == PB_WRONG_LE || hold_ff == PB_MORE) nxt_st = T_HDR;
          else if (case4_ff && sent_ff && warn) nxt_st = T_HDR;
          else nxt_st = T_IDLE;
        end
      end
      T_DOUT: if (tx_free && cnt_ff == 8'h01) nxt_st = T_PROC;
      T_DIN: if (rx_ok && cnt_ff == 8'h01) nxt_st = T_PROC;
      default: nxt_st = T_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= T_IDLE;
      rx_rdy_ff <= 1'b0;
      req_ready_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      rx_rdy_ff <= ~rsp_stall && (nxt_st == T_PROC || nxt_st == T_SW2 || nxt_st == T_DIN);
      req_ready_ff <= (nxt_st == T_IDLE) && !(t1_mode && !t1_active); // RULE15
    end
  end

  always_ff @(posedge clk) begin
    if (dat_we) dat_mem[dat_addr] <= dat_wdata;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < HDR_LEN; i++) begin
        hdr_ff[i] <= 8'h00;
      end
      idx_ff <= 8'h00;
      cnt_ff <= 8'h00;
      hold_ff <= 8'h00;
      tx_vld_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      has_data_ff <= 1'b0;
      sent_ff <= 1'b0;
      case4_ff <= 1'b0;
    end else begin
      if (tx_vld_ff && lnk.t2c_ready) tx_vld_ff <= 1'b0;
      case (st_ff)
        T_IDLE: if (req_valid && req_ready_ff) begin
          hdr_ff[0] <= req_cla;
          hdr_ff[1] <= req_ins;
          hdr_ff[2] <= req_p1;
          hdr_ff[3] <= req_p2;
          hdr_ff[4] <= req_p3;
          has_data_ff <= req_has_data;
          case4_ff <= req_has_data;
          sent_ff <= 1'b0;
          idx_ff <= 8'h00;
        end
        T_HDR: if (tx_free) begin
          tx_vld_ff <= 1'b1;
          tx_data_ff <= hdr_ff[idx_ff[2:0]];
          idx_ff <= (idx_ff == 8'(HDR_LEN - 1)) ? 8'h00 : idx_ff + 8'h01;
          if (idx_ff == 8'(HDR_LEN - 1)) cnt_ff <= hdr_ff[4];
        end
        T_PROC: if (rx_ok) begin
          hold_ff <= b;
          cnt_ff <= hdr_ff[4];
          idx_ff <= 8'h00;
        end
        T_SW2: if (rx_ok) begin
          idx_ff <= 8'h00;
          if (hold_ff == PB_WRONG_LE) begin
            hdr_ff[4] <= b; // RULE2
          end else if (hold_ff == PB_MORE || (case4_ff && sent_ff && warn)) begin
            hdr_ff[1] <= INS_GET_RESP; // RULE9 RULE16
            hdr_ff[2] <= GR_P12;
            hdr_ff[3] <= GR_P12;
            hdr_ff[4] <= (hold_ff == PB_MORE) ? b : LE_MAX;
            has_data_ff <= 1'b0;
            case4_ff <= 1'b0;
          end
        end
        T_DOUT: if (tx_free) begin
          tx_vld_ff <= 1'b1;
          tx_data_ff <= dat_mem[idx_ff];
          idx_ff <= idx_ff + 8'h01;
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h01) sent_ff <= 1'b1;
        end
        T_DIN: if (rx_ok) cnt_ff <= cnt_ff - 8'h01;
        default: begin
          sent_ff <= sent_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
      done_ff <= 1'b0;
      sw1_ff <= 8'h00;
      sw2_ff <= 8'h00;
    end else begin
      rsp_valid_ff <= (st_ff == T_DIN) && rx_ok;
      if (st_ff == T_DIN && rx_ok) rsp_data_ff <= b;
      done_ff <= (st_ff == T_SW2) && rx_ok && (nxt_st == T_IDLE);
      if (st_ff == T_SW2 && rx_ok && nxt_st == T_IDLE) begin
        sw1_ff <= hold_ff;
        sw2_ff <= b;
      end
    end
  end
endmodule

//--- testbench/link_checker.sv
`timescale 1ns/100ps
module link_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic t2c_valid,
  input wire logic t2c_ready,
  input wire logic [7:0] t2c_data,
  input wire logic c2t_valid,
  input wire logic c2t_ready,
  input wire logic [7:0] c2t_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_t2c_hold;
    t2c_valid && !t2c_ready |=> t2c_valid;
  endproperty
  a_t2c_hold: assert property (p_t2c_hold) else $error("terminal byte withdrawn");

  property p_t2c_data;
    t2c_valid && !t2c_ready |=> $stable(t2c_data);
  endproperty
  a_t2c_data: assert property (p_t2c_data) else $error("terminal byte changed");

  property p_c2t_hold;
    c2t_valid && !c2t_ready |=> c2t_valid;
  endproperty
  a_c2t_hold: assert property (p_c2t_hold) else $error("card byte lost in stall");

  property p_c2t_data;
    c2t_valid && !c2t_ready |=> $stable(c2t_data);
  endproperty
  a_c2t_data: assert property (p_c2t_data) else $error("card byte changed in stall");

  property p_reset_quiet;
    $rose(arst_n) |-> !c2t_valid && !t2c_valid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("link busy after reset");

  property p_ready_after_reset;
    $rose(arst_n) |=> t2c_ready;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset) else $error("card not ready");

  // A reply needs decode and answer cycles, so it cannot follow a byte at once
  property p_reply_gap;
    t2c_valid && t2c_ready |=> !c2t_valid [*2];
  endproperty
  a_reply_gap: assert property (p_reply_gap) else $error("reply too early");

  property p_term_waits;
    t2c_valid |-> !c2t_valid;
  endproperty
  a_term_waits: assert property (p_term_waits) else $error("terminal sent over reply");

  c_stall: cover property (c2t_valid && !c2t_ready);
  c_t2c_take: cover property (t2c_valid && t2c_ready);
  c_c2t_take: cover property (c2t_valid && c2t_ready);
  c_wrong_le: cover property (c2t_valid && c2t_ready && c2t_data == 8'h6C);
endmodule

//--- testbench/card_apdu_transport_handler_bench.sv
`timescale 1ns/100ps
module card_apdu_transport_handler_bench;
  import apdu_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic t1_mode = 1'b0;
  logic t1_active = 1'b0;
  logic [3:0] pin_retries = 4'h3;
  logic req_valid = 1'b0;
  logic [7:0] req_ins = 8'h00;
  logic [7:0] req_p3 = 8'h00;
  logic req_has_data = 1'b0;
  logic we = 1'b0;
  logic [7:0] wa = 8'h00;
  logic rsp_stall = 1'b0;
  logic ans_valid = 1'b0;
  logic [26:0] ans = '0;
  logic [26:0] h_ans = '0;
  logic [26:0] c_ans = '0;
  logic ph = 1'b0;
  logic pc = 1'b0;
  logic req_ready, rsp_valid, done, hdr_valid, cmd_valid, cmd_end;
  logic [7:0] rsp_data, done_sw1, done_sw2, hdr_p3, cmd_data;
  logic [7:0] rq[$];
  logic [7:0] cq[$];
  int failures = 0;
  int samples_checked = 0;

  always #2 clk = ~clk;

  apdu_link_if apdu_link_if_i ();

  card_apdu_end card_apdu_end_i (.clk(clk), .arst_n(arst_n), .lnk(apdu_link_if_i.card),
    .t1_mode(t1_mode), .pin_retries(pin_retries), .hdr_valid(hdr_valid), .hdr_ins(),
    .hdr_p1(), .hdr_p2(), .hdr_p3(hdr_p3), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_end(cmd_end), .ans_valid(ans_valid), .ans_badp(ans[26]), .ans_ok(ans[25]),
    .ans_indata(ans[24]), .ans_len(ans[23:16]), .ans_sw1(ans[15:8]), .ans_sw2(ans[7:0]),
    .rsp_we(we), .rsp_addr(wa), .rsp_wdata(wa + 8'hA1));

  term_apdu_end term_apdu_end_i (.clk(clk), .arst_n(arst_n), .lnk(apdu_link_if_i.term),
    .t1_mode(t1_mode), .t1_active(t1_active), .req_valid(req_valid), .req_ready(req_ready),
    .req_cla(8'h00), .req_ins(req_ins), .req_p1(8'h00), .req_p2(8'h00), .req_p3(req_p3),
    .req_has_data(req_has_data), .dat_we(we), .dat_addr(wa), .dat_wdata(wa + 8'h11),
    .rsp_stall(rsp_stall), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done),
    .done_sw1(done_sw1), .done_sw2(done_sw2));

  link_checker link_checker_i (.clk(clk), .arst_n(arst_n),
    .t2c_valid(apdu_link_if_i.t2c_valid), .t2c_ready(apdu_link_if_i.t2c_ready),
    .t2c_data(apdu_link_if_i.t2c_data), .c2t_valid(apdu_link_if_i.c2t_valid),
    .c2t_ready(apdu_link_if_i.c2t_ready), .c2t_data(apdu_link_if_i.c2t_data));

  // Application answers one cycle late so the card is surely waiting for it
  always @(negedge clk) begin
    ans_valid <= ph | pc;
    ans <= ph ? h_ans : c_ans;
    ph <= hdr_valid;
    pc <= cmd_end;
  end

  always @(posedge clk) begin
    if (rsp_valid === 1'b1) rq.push_back(rsp_data);
    if (cmd_valid === 1'b1) cq.push_back(cmd_data);
  end

  task automatic conclude();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_rsp(input int n, input logic [15:0] sw);
    check(16'(rq.size()), 16'(n));
    for (int i = 0; i < n && i < rq.size(); i++) check({8'h00, rq[i]}, 16'(8'hA1 + i));
    check({done_sw1, done_sw2}, sw);
  endtask

  task automatic run(input logic [7:0] ins, input logic [7:0] p3, input logic hd);
    int n;
    rq.delete();
    cq.delete();
    @(negedge clk);
    req_ins = ins;
    req_p3 = p3;
    req_has_data = hd;
    req_valid = 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (req_ready === 1'b1) break;
    end
    if (n >= 100) begin
      failures++;
      conclude();
    end
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 4000; n++) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    if (n >= 4000) begin
      failures++;
      conclude();
    end
  endtask

  task automatic case2_correction();
    logic [7:0] p3s [2] = '{8'h00, 8'h15};
    h_ans = {3'b010, 8'd11, SW1_OK, SW2_OK};
    for (int k = 0; k < 2; k++) begin
      fork
        run(8'hB0, p3s[k], 1'b0);
        begin
          repeat (30) @(negedge clk);
          rsp_stall = 1'b1;
          repeat (12) @(negedge clk);
          rsp_stall = 1'b0;
        end
      join
      expect_rsp(11, 16'h9000);
      check({8'h00, hdr_p3}, 16'h000B);
    end
  endtask

  task automatic case2_short();
    h_ans = {3'b010, 8'd11, SW1_OK, SW2_OK};
    run(8'hB0, 8'h05, 1'b0);
    expect_rsp(11, 16'h9000);
    check({8'h00, hdr_p3}, 16'h0006);
  endtask

  task automatic case2_abnormal();
    logic [7:0] p3s [3] = '{8'h00, 8'h0B, 8'h05};
    for (int k = 0; k < 3; k++) begin
      h_ans = {3'b100, 8'd11, SW1_OK, SW2_OK};
      run(8'hB0, p3s[k], 1'b0);
      expect_rsp(0, 16'h6B00);
      h_ans = {3'b000, 8'd11, SW1_OK, SW2_OK};
      run(8'hB0, p3s[k], 1'b0);
      expect_rsp(0, 16'h6F00);
    end
  endtask

  task automatic case4();
    h_ans = {3'b011, 8'd0, SW1_OK, SW2_OK};
    c_ans = {3'b010, 8'd3, SW1_OK, SW2_OK};
    run(8'hA4, 8'h02, 1'b1);
    check(16'(cq.size()), 16'd2);
    check({cq[0], cq[1]}, 16'h1112);
    expect_rsp(3, 16'h9000);
    c_ans = {3'b000, 8'd0, SW1_OK, SW2_OK};
    run(8'hA4, 8'h02, 1'b1);
    expect_rsp(0, 16'h6F00);
    c_ans = {3'b010, 8'd0, SW1_OK, SW2_OK};
    run(8'hA4, 8'h02, 1'b1);
    expect_rsp(0, 16'h6F00);
    // A warning makes the terminal fetch with Le 00; nothing is pending
    c_ans = {3'b000, 8'd0, SW1_WARN, 8'h83};
    run(8'hA4, 8'h02, 1'b1);
    expect_rsp(0, 16'h6F00);
    check({8'h00, hdr_p3}, 16'h0000);
  endtask

  task automatic verify_empty();
    h_ans = {3'b010, 8'd0, SW1_OK, SW2_OK};
    run(INS_VERIFY, 8'h00, 1'b0);
    expect_rsp(0, 16'h63C3);
    @(negedge clk);
    pin_retries = 4'h0;
    run(INS_VERIFY, 8'h00, 1'b0);
    expect_rsp(0, 16'h63C0);
  endtask

  // Block mode drops the acknowledge byte; a stray one would shift the data
  task automatic block_mode();
    @(negedge clk);
    t1_mode = 1'b1;
    t1_active = 1'b0;
    repeat (2) @(negedge clk);
    check({15'h0000, req_ready}, 16'h0000);
    t1_active = 1'b1;
    h_ans = {3'b010, 8'd3, SW1_OK, SW2_OK};
    run(8'hB0, 8'h03, 1'b0);
    expect_rsp(3, 16'h9000);
    @(negedge clk);
    t1_mode = 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    we = 1'b1;
    for (int i = 0; i < 256; i++) begin
      wa = i[7:0];
      @(negedge clk);
    end
    we = 1'b0;
    case2_correction();
    case2_short();
    case2_abnormal();
    case4();
    verify_empty();
    block_mode();
    conclude();
  end
endmodule
